// >>> verilog/tdm_port_defines.vh
// constants of the multiplexed command and audio port
// Operation
// - chain select bit 29 low addresses us
// - device ID sits in bits 28 to 24
// - chain input tied high gives ID 1
// - ID 0x1F on write is broadcast
// - ID 0x00 selects nobody
// - bit 23 high means register read
// - register ID in bits 22 to 16
// - data byte 15 to 8 is written
// - low byte ignored, never driven out
// - extended fields decode alike, bit 31 reserved
// - audio is 32 bits, 24-bit sample on top
// - disable bit in reg 19, ID in reg 23
// - read data shifts out same field
// - sample on bit clock rise, drive on fall
// - driver enabled one bit early
// - chain output high during our last channel
// - chain input high claims next channel
// - inactive device passes chain input through outside bit 31 frames
// - mode after two frames with 2-bit sync
// - bit 31 frame only assigns IDs
// - extended flag means no audio in frame
// - first field after sync is command
`ifndef TDM_PORT_DEFINES_VH
`define TDM_PORT_DEFINES_VH
// ****************************************
// field layout
// ****************************************
`define B_ID_ASSIGN 31
`define B_EXT 30
`define B_CHAIN 29
`define B_DEV_HI 28
`define B_DEV_LO 24
`define B_RW 23
`define B_REG_HI 22
`define B_REG_LO 16
`define B_DATA_HI 15
`define B_DATA_LO 8
`define B_AUD_HI 31
`define B_AUD_LO 8
// ****************************************
// bit positions within a field
// ****************************************
`define IDX_HDR 5'h08
`define IDX_OE 5'h0F
`define IDX_FIRST 5'h10
`define IDX_LASTRD 5'h17
`define IDX_LAST 5'h1F
// ****************************************
// ids, registers, counts
// ****************************************
`define DEV_BCAST 5'h1F
`define DEV_NONE 5'h00
`define DEV_MAX 6'h1E
`define REG_OPE 7'h13
`define OPE_BIT 0
`define REG_DEVID 7'h17
`define REG_RESET 8'h00
`define FS_PULSE 3'h2
`define MODE_FRAMES 2'h2
`endif

// >>> verilog/pin_sync.v
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter W = 4
) (
  input wire core_clk,
  input wire rstn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/mode_regs.v
// mode register array, link port and local port
`timescale 1ns/10ps
`default_nettype none
`include "tdm_port_defines.vh"
module mode_regs #(
  parameter AW = 7,
  parameter DW = 8
) (
  input wire core_clk,
  input wire rstn,
  input wire a_we,
  input wire [AW-1:0] a_waddr,
  input wire [DW-1:0] a_wdata,
  input wire [AW-1:0] a_raddr,
  output wire [DW-1:0] a_rdata,
  input wire b_we,
  input wire b_re,
  input wire [AW-1:0] b_addr,
  input wire [DW-1:0] b_wdata,
  output reg [DW-1:0] b_rdata,
  output wire channel_output_enable,
  output wire [4:0] dev_id
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;
  // link write wins a same-address clash: the host owns the link
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        mem[i] <= `REG_RESET;
      end
      b_rdata <= {DW{1'b0}};
    end else begin
      if (b_we && !(a_we && a_waddr == b_addr)) begin
        mem[b_addr] <= b_wdata;
      end
      if (a_we) begin
        mem[a_waddr] <= a_wdata;
      end
      b_rdata <= b_re ? mem[b_addr] : {DW{1'b0}};
    end
  end
  assign a_rdata = mem[a_raddr];
  assign channel_output_enable = mem[`REG_OPE][`OPE_BIT];
  assign dev_id = mem[`REG_DEVID][4:0];
endmodule
`default_nettype wire

// >>> verilog/tdm_command_audio.v
// multiplexed command and audio serial port, input-chain slave
`timescale 1ns/10ps
`default_nettype none
`include "tdm_port_defines.vh"
module tdm_command_audio #(
  parameter FW = 6
) (
  input wire core_clk,
  input wire rstn,
  input wire bit_clock,
  input wire frame_sync,
  input wire frame_data_in,
  input wire chain_in,
  output reg cmd_data_out,
  output reg cmd_data_oe_n,
  output reg chain_out,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  output reg tdm_mode,
  output wire [4:0] dev_id,
  output reg [23:0] sample_left,
  output reg [23:0] sample_right,
  output reg sample_valid
);
  // ****************************************
  // pin synchronisation and edges
  // ****************************************
  wire [3:0] pins_s;
  wire bck_s;
  wire fs_s;
  wire di_s;
  wire ci_s;
  reg bck_prev_q;
  pin_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .d({bit_clock, frame_sync, frame_data_in, chain_in}),
    .q(pins_s)
  );
  assign bck_s = pins_s[3];
  assign fs_s = pins_s[2];
  assign di_s = pins_s[1];
  assign ci_s = pins_s[0];
  // all four pins share one delay, so data and sync stay aligned to the clock
  wire rise = bck_s & ~bck_prev_q;
  wire fall = ~bck_s & bck_prev_q;

  // ****************************************
  // state
  // ****************************************
  reg fs_prev_q;
  reg [2:0] fs_hi_q;
  reg [1:0] good_q;
  reg [4:0] cnt_q;
  reg [FW-1:0] field_q;
  reg [30:0] sh_q;
  reg ext_q;
  reg quiet_q;
  reg idf_q;
  reg idgot_q;
  reg rdhit_q;
  reg [1:0] own_q;
  reg [7:0] obyte_q;

  wire channel_output_enable;
  wire [6:0] rd_reg;
  wire [7:0] link_rdata;
  reg lw_en;
  reg [6:0] lw_addr;
  reg [7:0] lw_data;

  wire fs_start = s_fs_start(fs_s, fs_prev_q);
  wire field0 = (field_q == {FW{1'b0}});
  // first field after sync is the command, later ones are extended while flagged
  wire cmd_field = field0 | ext_q;
  wire [31:0] word = {sh_q, di_s};
  wire [8:0] hdr = {sh_q[7:0], di_s};
  wire chan_en = ~channel_output_enable;

  function s_fs_start;
    input cur;
    input prev;
    begin
      s_fs_start = cur & ~prev;
    end
  endfunction

  // address match used for early read decode and for the write at field end
  function hit;
    input chain;
    input [4:0] dev;
    input rw;
    input [4:0] mine;
    begin
      hit = 1'b0;
      if (!chain && dev != `DEV_NONE) begin
        if (dev == `DEV_BCAST) begin
          hit = !rw;
        end else if (mine != `DEV_NONE && dev == mine) begin
          hit = 1'b1;
        end
      end
    end
  endfunction

  // ****************************************
  // register array
  // ****************************************
  assign rd_reg = sh_q[6:0];
  mode_regs #(.AW(7), .DW(8)) u_regs (
    .core_clk(core_clk),
    .rstn(rstn),
    .a_we(lw_en),
    .a_waddr(lw_addr),
    .a_wdata(lw_data),
    .a_raddr(rd_reg),
    .a_rdata(link_rdata),
    .b_we(reg_wr),
    .b_re(reg_rd),
    .b_addr(reg_addr),
    .b_wdata(reg_wdata),
    .b_rdata(reg_rdata),
    .channel_output_enable(channel_output_enable),
    .dev_id(dev_id)
  );

  // ****************************************
  // link-side register writes
  // ****************************************
  always @* begin
    lw_en = 1'b0;
    lw_addr = word[`B_REG_HI:`B_REG_LO];
    lw_data = word[`B_DATA_HI:`B_DATA_LO];
    if (rise && !fs_start && cnt_q == `IDX_LAST && tdm_mode) begin
      if (cmd_field && !(field0 && word[`B_ID_ASSIGN])) begin
        lw_en = !word[`B_RW] &&
                hit(word[`B_CHAIN], word[`B_DEV_HI:`B_DEV_LO], word[`B_RW], dev_id);
      end else if (idf_q && !idgot_q && ci_s && !field0 && {1'b0, field_q} <= {1'b0, `DEV_MAX}) begin
        // position in the chain is the field where our chain input rose
        lw_en = 1'b1;
        lw_addr = `REG_DEVID;
        lw_data = {3'h0, field_q[4:0]};
      end
    end
  end

  // the field about to start carries no audio
  wire nxt_quiet = quiet_q | idf_q | ext_q |
                   (cmd_field && ((field0 && word[`B_ID_ASSIGN]) || word[`B_EXT]));

  // ****************************************
  // frame tracking on bit clock rise
  // ****************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bck_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      fs_hi_q <= 3'h0;
      good_q <= 2'h0;
      tdm_mode <= 1'b0;
      cnt_q <= 5'h00;
      field_q <= {FW{1'b0}};
      sh_q <= 31'h00000000;
      ext_q <= 1'b0;
      quiet_q <= 1'b0;
      idf_q <= 1'b0;
      idgot_q <= 1'b0;
      rdhit_q <= 1'b0;
      own_q <= 2'h0;
      sample_left <= 24'h000000;
      sample_right <= 24'h000000;
      sample_valid <= 1'b0;
    end else begin
      bck_prev_q <= bck_s;
      sample_valid <= 1'b0;
      if (rise) begin
        fs_prev_q <= fs_s;
        sh_q <= {sh_q[29:0], di_s};
        // sync width decides the mode; a 50% duty clock drops it
        if (fs_start) begin
          fs_hi_q <= 3'h1;
        end else if (fs_s && fs_hi_q != 3'h7) begin
          fs_hi_q <= fs_hi_q + 3'h1;
        end
        if (!fs_s && fs_prev_q) begin
          if (fs_hi_q == `FS_PULSE) begin
            if (good_q != `MODE_FRAMES) begin
              good_q <= good_q + 2'h1;
            end
            if (good_q >= `MODE_FRAMES - 2'h1) begin
              tdm_mode <= 1'b1;
            end
          end else begin
            good_q <= 2'h0;
            tdm_mode <= 1'b0;
          end
        end
        if (fs_start) begin
          // the bit sampled with the sync edge is command bit 31
          cnt_q <= 5'h01;
          field_q <= {FW{1'b0}};
          ext_q <= 1'b0;
          quiet_q <= 1'b0;
          idf_q <= 1'b0;
          idgot_q <= 1'b0;
          rdhit_q <= 1'b0;
          own_q <= 2'h0;
        end else begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == `IDX_HDR && cmd_field) begin
            // header known at bit 23; register ID follows in time for the read
            rdhit_q <= tdm_mode && !(field0 && hdr[8]) && hdr[0] &&
                       hit(hdr[6], hdr[5:1], hdr[0], dev_id);
          end
          if (cnt_q == `IDX_LAST) begin
            rdhit_q <= 1'b0;
            if (field_q != {FW{1'b1}}) begin
              field_q <= field_q + {{(FW-1){1'b0}}, 1'b1};
            end
            if (cmd_field) begin
              if (field0 && word[`B_ID_ASSIGN]) begin
                idf_q <= 1'b1;
                quiet_q <= 1'b1;
                ext_q <= 1'b0;
              end else begin
                ext_q <= word[`B_EXT];
                if (word[`B_EXT]) begin
                  quiet_q <= 1'b1;
                end
              end
            end
            if (lw_en && lw_addr == `REG_DEVID && idf_q) begin
              idgot_q <= 1'b1;
            end
            // channel ownership: left, right, then done
            if (own_q == 2'h1) begin
              sample_left <= word[`B_AUD_HI:`B_AUD_LO];
              own_q <= 2'h2;
            end else if (own_q == 2'h2) begin
              sample_right <= word[`B_AUD_HI:`B_AUD_LO];
              sample_valid <= 1'b1;
              own_q <= 2'h3;
            end else if (own_q == 2'h0 && ci_s && chan_en && tdm_mode && !nxt_quiet) begin
              own_q <= 2'h1;
            end
          end
        end
      end
    end
  end

  // ****************************************
  // read data out on bit clock fall
  // ****************************************
  // only bits 16..8 are driven, bit 16 as a zero; the low byte stays released
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_data_out <= 1'b0;
      cmd_data_oe_n <= 1'b1;
      obyte_q <= 8'h00;
    end else if (fall) begin
      if (rdhit_q && cnt_q >= `IDX_OE && cnt_q <= `IDX_LASTRD) begin
        if (cnt_q == `IDX_OE) begin
          cmd_data_oe_n <= 1'b0;
          cmd_data_out <= 1'b0;
        end else if (cnt_q == `IDX_FIRST) begin
          cmd_data_out <= link_rdata[7];
          obyte_q <= {link_rdata[6:0], 1'b0};
        end else begin
          cmd_data_out <= obyte_q[7];
          obyte_q <= {obyte_q[6:0], 1'b0};
        end
      end else begin
        cmd_data_oe_n <= 1'b1;
        cmd_data_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // daisy chain output
  // ****************************************
  // passthrough costs a few core cycles per device, small against a bit period
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chain_out <= 1'b0;
    end else if (idf_q) begin
      chain_out <= idgot_q;
    end else if (!chan_en) begin
      chain_out <= ci_s;
    end else begin
      chain_out <= (own_q == 2'h2);
    end
  end
endmodule
`default_nettype wire

// >>> tb/tdm_port_checker_sva.sv
// pin-level assertions for the multiplexed port
`timescale 1ns/10ps
`default_nettype none
`include "tdm_port_defines.vh"
module tdm_port_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic bit_clock,
  input wire logic cmd_data_out,
  input wire logic cmd_data_oe_n,
  input wire logic tdm_mode,
  input wire logic sample_valid,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [4:0] dev_id
);
  // ********************
  // edge age in core cycles
  // ********************
  logic bck_q;
  logic [2:0] since_fall, since_rise;
  logic [3:0] fall_cnt;
  logic [4:0] wd_q;
  wire logic fall_w = bck_q & ~bit_clock;
  wire logic rise_w = ~bck_q & bit_clock;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bck_q <= 1'b0;
      since_fall <= 3'h7;
      since_rise <= 3'h7;
      fall_cnt <= 4'h0;
      wd_q <= 5'h00;
    end else begin
      bck_q <= bit_clock;
      since_fall <= fall_w ? 3'h0 : since_fall + {2'h0, since_fall != 3'h7};
      since_rise <= rise_w ? 3'h0 : since_rise + {2'h0, since_rise != 3'h7};
      fall_cnt <= cmd_data_oe_n ? 4'h0 : fall_cnt + {3'h0, fall_w};
      wd_q <= reg_wdata[4:0];
    end
  end
  // ********************
  // properties: the pins are seen three cycles late, so 5 leaves margin but runs past the 4-cycle half bit
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence drv_on;
    $fell(cmd_data_oe_n);
  endsequence
  sequence drv_hold;
    !cmd_data_out ##1 (!cmd_data_oe_n) [*8];
  endsequence
  AST_OE_IDLE: assert property (!tdm_mode |-> cmd_data_oe_n)
    else $error("driver on out of mode");
  AST_DOUT_REL: assert property (cmd_data_oe_n |-> !cmd_data_out)
    else $error("data while released");
  AST_DRV_START: assert property (drv_on |-> drv_hold)
    else $error("driver window short");
  AST_OE_LEN: assert property ($rose(cmd_data_oe_n) |-> fall_cnt == 4'h9)
    else $error("driver window length");
  AST_DRIVE_FALL: assert property (!$stable({cmd_data_out, cmd_data_oe_n}) |-> since_fall <= 3'h5)
    else $error("output moved off a fall");
  AST_MODE_RISE: assert property ($rose(tdm_mode) |-> since_rise <= 3'h5)
    else $error("mode entry off a rise");
  AST_SAMPLE_RISE: assert property (sample_valid |-> tdm_mode && since_rise <= 3'h5)
    else $error("sample off a rise");
  AST_DEVID_WR: assert property (reg_wr && reg_addr == `REG_DEVID |=> dev_id == wd_q)
    else $error("id register not written");
endmodule
bind tdm_command_audio tdm_port_checker u_chk (.core_clk(core_clk), .rstn(rstn), .bit_clock(bit_clock),
  .cmd_data_out(cmd_data_out), .cmd_data_oe_n(cmd_data_oe_n), .tdm_mode(tdm_mode), .sample_valid(sample_valid),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .dev_id(dev_id));
`default_nettype wire

// >>> tb/tdm_host_model.sv
// host model driving the multiplexed frame
`timescale 1ns/10ps
`default_nettype none
module tdm_host_model (
  output logic bit_clock,
  output logic frame_sync,
  output logic frame_data_in,
  input wire logic dout_wire
);
  logic [31:0] fld [0:3];
  logic [7:0] rd_byte;
  int sync_len = 2;
  int b;
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    frame_data_in = 1'b0;
  end
  // ********************
  // one frame; the clock stands still between frames
  // ********************
  task automatic send(input int n);
    for (b = 0; b < 32 * n; b++) begin
      frame_sync = b < sync_len;
      frame_data_in = fld[b / 32][31 - b % 32];
      #40 bit_clock = 1'b1;
      if (b >= 16 && b < 24) rd_byte = {rd_byte[6:0], dout_wire};
      #40 bit_clock = 1'b0;
    end
    frame_sync = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/test_tdm_command_audio.sv
// self-checking bench of the multiplexed port
`timescale 1ns/10ps
`default_nettype none
`include "tdm_port_defines.vh"
module test_tdm_command_audio;
  logic core_clk, rstn, chain_in, reg_wr, reg_rd;
  logic [6:0] reg_addr, a;
  logic [7:0] reg_wdata, v, r;
  logic [23:0] sl, sr;
  logic [3:0] co_bits;
  logic dout_last = 1'b0;
  wire bit_clock, frame_sync, frame_data_in, dout_wire, cmd_data_out, cmd_data_oe_n, chain_out, tdm_mode, sample_valid;
  wire [7:0] reg_rdata;
  wire [4:0] dev_id;
  wire [23:0] sample_left, sample_right;
  int mismatches = 0, cmp_count = 0, cycles = 0, seed = 32'hF8A4, sv_count = 0;
  // released line shows the inverse of its last value, never a lucky match
  assign dout_wire = cmd_data_oe_n ? ~dout_last : cmd_data_out;
  tdm_command_audio uut (.core_clk(core_clk), .rstn(rstn), .bit_clock(bit_clock), .frame_sync(frame_sync),
    .frame_data_in(frame_data_in), .chain_in(chain_in), .cmd_data_out(cmd_data_out), .cmd_data_oe_n(cmd_data_oe_n),
    .chain_out(chain_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tdm_mode(tdm_mode), .dev_id(dev_id), .sample_left(sample_left),
    .sample_right(sample_right), .sample_valid(sample_valid));
  tdm_host_model u_host (.bit_clock(bit_clock), .frame_sync(frame_sync), .frame_data_in(frame_data_in),
    .dout_wire(dout_wire));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (!cmd_data_oe_n) dout_last <= cmd_data_out;
    if (sample_valid === 1'b1) sv_count <= sv_count + 1;
    if (cycles == 80000) begin
      mismatches++;
      end_sim();
    end
  end
  always @(posedge bit_clock) if (u_host.b % 32 == 16) co_bits[u_host.b / 32] <= chain_out;
  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] cmd(input logic ext, chain, input logic [4:0] id, input logic rw,
    input logic [6:0] ad, input logic [7:0] d);
    return {1'b0, ext, chain, id, rw, ad, d, ~d};
  endfunction
  function automatic logic [4:0] id_of(input int k);
    return k == 2 ? `DEV_NONE : k == 3 ? `DEV_BCAST : (k == 1 || k == 5) ? 5'h02 : 5'h01;
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [6:0] ad, output logic [7:0] q);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk) q = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic frame(input int n);
    @(posedge core_clk);
    #3 u_host.send(n);
    repeat (6) @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ********************
  // scenarios
  // ********************
  initial begin
    {rstn, chain_in, reg_wr, reg_rd} = 4'h0;
    {reg_addr, reg_wdata} = 15'h0000;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    check(cmd_data_oe_n, 1'b1);
    rd(`REG_DEVID, r);
    check(r, 8'h00);
    u_host.fld[0] = 32'h0;
    u_host.sync_len = 3;
    frame(1);
    u_host.sync_len = 2;
    frame(1);
    check(tdm_mode, 1'b0);
    frame(1);
    check(tdm_mode, 1'b1);
    chain_in <= 1'b1;
    u_host.fld[0] = 32'h8000_0000 | cmd(1'b0, 1'b0, `DEV_BCAST, 1'b0, 7'h05, 8'h5A);
    u_host.fld[1] = $random(seed);
    u_host.fld[2] = $random(seed);
    frame(3);
    check(dev_id, 5'h01);
    rd(7'h05, r);
    check(r, 8'h00);
    wr(`REG_DEVID, 8'h01);
    for (int k = 0; k < 6; k++) begin
      a = 7'h20 + 7'(k);
      v = 8'($random(seed));
      wr(a, ~v);
      u_host.fld[0] = cmd(k == 5, k == 4, id_of(k), 1'b0, a, v);
      u_host.fld[1] = cmd(1'b0, 1'b0, 5'h01, 1'b0, a, v) | 32'h8000_0000;
      frame(k == 5 ? 2 : 1);
      rd(a, r);
      check(r, 8'((k == 0 || k == 3 || k == 5) ? v : ~v));
    end
    repeat (3) begin
      a = {2'b01, 5'($random(seed))};
      v = 8'($random(seed));
      wr(a, v);
      rd(a, r);
      check(r, v);
      u_host.fld[0] = cmd(1'b0, 1'b0, 5'h01, 1'b1, a, ~v);
      frame(1);
      check(u_host.rd_byte, v);
    end
    repeat (2) begin
      sl = 24'($random(seed));
      sr = 24'($random(seed));
      u_host.fld[0] = cmd(1'b0, 1'b0, 5'h00, 1'b0, 7'h00, 8'h00);
      u_host.fld[1] = {sl, 8'h00};
      u_host.fld[2] = {sr, 8'h00};
      co_bits = 4'h0;
      frame(3);
      check({sample_left, sample_right}, {sl, sr});
      check(co_bits, 4'h4);
    end
    wr(`REG_OPE, 8'h01);
    u_host.fld[1] = 32'h0;
    co_bits = 4'h0;
    frame(3);
    check(sample_left, sl);
    check(co_bits, 4'h7);
    check(sv_count, 32'h2);
    chain_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(chain_out, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
